/* logic/gpd_pkg.sv */
// constants for the gpio port data control block
package gpd_pkg;
  localparam int          PIN_COUNT       = 8;
  localparam int          ADDR_W          = 10;
  localparam int          MASK_LSB        = 2;
  localparam int          MASK_MSB        = 9;
  localparam logic [9:0]  ADDR_DATA_BASE  = 10'h000;
  localparam logic [9:0]  ADDR_DATA_LAST  = 10'h3fc;
  localparam logic [7:0]  DEF_ZERO        = 8'h00;
  localparam logic [1:0]  DRIVE_2MA       = 2'h0;
  localparam logic [1:0]  DRIVE_4MA       = 2'h1;
  localparam logic [1:0]  DRIVE_8MA       = 2'h2;
  localparam logic [15:0] DEF_DRIVE       = 16'h0000;
endpackage

/* logic/gpd_port.sv */
// one gpio port: direction, masked data access, pad settings, pin interrupts
// How it works
// - pins reset undriven, pad bits cleared except pull-up and input enable on debug pins
// - debug pins reset to debug function
// - any reset restores all pin defaults
// - direction 0 captures pin level into data
// - direction 1 drives data bit onto pin when alt function is off; open-drain pins drive only a 0 and release a 1
// - address bits 9:2 mask data access
// - data storage aliases across 256 words
// - write changes only mask-selected bits
// - read returns zero for unmasked bits
// - one reusable block, instanced per port
// - edge interrupt rising, falling or both
// - level interrupt while high or low
// - per-pin pull, drive, open-drain, input enable
// - all unmasked pin interrupts merged into one output
// - clear write of one clears latch
// - raw status unmasked, masked status gated
`timescale 1ns/100ps
module gpd_port #(
  parameter logic [7:0] DEBUG_PINS = 8'h00
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_arst_n,
  // data register access
  input  wire logic                          i_data_wr,
  input  wire logic                          i_data_rd,
  input  wire logic [gpd_pkg::ADDR_W-1:0]    i_data_addr,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_data_wdata,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_data_rdata,
  // configuration
  input  wire logic                          i_cfg_we,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_dir,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_alt_function_select,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_digital_input_enable,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_pull_up_enable,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_pull_down_enable,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_open_drain_enable,
  input  wire logic [2*gpd_pkg::PIN_COUNT-1:0] i_drive_sel,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_slew_enable,
  // interrupt configuration
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_irq_sense_level,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_irq_both_edges,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_irq_event_high,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_irq_mask,
  input  wire logic                          i_irq_clear_we,
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_irq_clear_reg,
  // pins
  input  wire logic [gpd_pkg::PIN_COUNT-1:0] i_pin,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_pin,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_pin_oe,
  // pad settings shown
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_pin_direction_reg,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_alt_function_select,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_digital_input_enable,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_pull_up_enable,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_pull_down_enable,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_open_drain_enable,
  output logic      [2*gpd_pkg::PIN_COUNT-1:0] o_drive_sel,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_slew_enable,
  // interrupt status
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_raw_irq_status,
  output logic      [gpd_pkg::PIN_COUNT-1:0] o_masked_irq_status,
  output logic                               o_irq
);
  import gpd_pkg::*;

  logic [PIN_COUNT-1:0]   dir_reg, dir_next;
  logic [PIN_COUNT-1:0]   afs_reg, afs_next;
  logic [PIN_COUNT-1:0]   den_reg, den_next;
  logic [PIN_COUNT-1:0]   pu_reg, pu_next;
  logic [PIN_COUNT-1:0]   pd_reg, pd_next;
  logic [PIN_COUNT-1:0]   od_reg, od_next;
  logic [2*PIN_COUNT-1:0] drv_reg, drv_next;
  logic [PIN_COUNT-1:0]   slr_reg, slr_next;
  logic [PIN_COUNT-1:0]   sync1_reg, sync2_reg, prev_reg;
  logic [PIN_COUNT-1:0]   out_reg, out_next;
  logic [PIN_COUNT-1:0]   rdata_reg, rdata_next;
  logic [PIN_COUNT-1:0]   latch_reg, latch_next;
  logic [PIN_COUNT-1:0]   data_view, mask, raw;
  logic                   in_range;
  logic [PIN_COUNT-1:0]   slew_ok;
  logic [2:0]             arm_reg;

  // configuration registers
  always_comb begin
    dir_next = dir_reg;
    afs_next = afs_reg;
    den_next = den_reg;
    pu_next  = pu_reg;
    pd_next  = pd_reg;
    od_next  = od_reg;
    drv_next = drv_reg;
    slr_next = slr_reg;
    if (i_cfg_we) begin
      dir_next = i_dir;
      afs_next = i_alt_function_select;
      den_next = i_digital_input_enable;
      pu_next  = i_pull_up_enable;
      pd_next  = i_pull_down_enable;
      od_next  = i_open_drain_enable;
      drv_next = i_drive_sel;
      slr_next = i_slew_enable & slew_ok;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dir_reg <= DEF_ZERO;
      afs_reg <= DEF_ZERO | DEBUG_PINS;
      den_reg <= DEF_ZERO | DEBUG_PINS;
      pu_reg  <= DEF_ZERO | DEBUG_PINS;
      pd_reg  <= DEF_ZERO;
      od_reg  <= DEF_ZERO;
      drv_reg <= DEF_DRIVE;
      slr_reg <= DEF_ZERO;
    end else begin
      dir_reg <= dir_next;
      afs_reg <= afs_next;
      den_reg <= den_next;
      pu_reg  <= pu_next;
      pd_reg  <= pd_next;
      od_reg  <= od_next;
      drv_reg <= drv_next;
      slr_reg <= slr_next;
    end
  end

  // two-stage input synchroniser
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_reg <= DEF_ZERO;
      sync2_reg <= DEF_ZERO;
      prev_reg  <= DEF_ZERO;
      arm_reg   <= 3'h0;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      // edges held off until prev_reg holds a real pin level, no false edge after reset
      arm_reg   <= {arm_reg[1:0], 1'b1};
    end
  end

  // data path with address mask
  assign mask      = i_data_addr[MASK_MSB:MASK_LSB];
  assign in_range  = (i_data_addr >= ADDR_DATA_BASE) && (i_data_addr <= ADDR_DATA_LAST);
  assign data_view = (dir_reg & out_reg) | (~dir_reg & sync2_reg);

  always_comb begin
    out_next   = out_reg;
    rdata_next = rdata_reg;
    if (i_data_wr && in_range) begin
      out_next = (out_reg & ~mask) | (i_data_wdata & mask);
    end
    if (i_data_rd && in_range) begin
      rdata_next = data_view & mask;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_reg   <= DEF_ZERO;
      rdata_reg <= DEF_ZERO;
    end else begin
      out_reg   <= out_next;
      rdata_reg <= rdata_next;
    end
  end

  // slew limiting only takes effect on 8 mA pads
  for (genvar s = 0; s < PIN_COUNT; s++) begin : g_slew
    assign slew_ok[s] = (i_drive_sel[2*s +: 2] == DRIVE_8MA);
  end

  // interrupt detection per pin
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_irq
      logic rise, fall, edge_hit;
      assign rise     = sync2_reg[g] & ~prev_reg[g];
      assign fall     = ~sync2_reg[g] & prev_reg[g];
      assign edge_hit = arm_reg[2] & (i_irq_both_edges[g] ? (rise | fall)
                      : (i_irq_event_high[g] ? rise : fall));
      always_comb begin
        latch_next[g] = latch_reg[g];
        if (i_irq_clear_we && i_irq_clear_reg[g]) begin
          latch_next[g] = 1'b0;
        end
        if (!i_irq_sense_level[g] && edge_hit) begin
          latch_next[g] = 1'b1; // set wins over clear
        end
        raw[g] = i_irq_sense_level[g]
               ? (sync2_reg[g] == i_irq_event_high[g])
               : latch_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_reg <= DEF_ZERO;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // outputs
  assign o_pin                  = out_reg;
  assign o_pin_oe               = dir_reg & ~afs_reg & (~od_reg | ~out_reg);
  assign o_data_rdata           = rdata_reg;
  assign o_pin_direction_reg    = dir_reg;
  assign o_alt_function_select  = afs_reg;
  assign o_digital_input_enable = den_reg;
  assign o_pull_up_enable       = pu_reg;
  assign o_pull_down_enable     = pd_reg;
  assign o_open_drain_enable    = od_reg;
  assign o_drive_sel            = drv_reg;
  assign o_slew_enable          = slr_reg;
  assign o_raw_irq_status       = raw;
  assign o_masked_irq_status    = raw & i_irq_mask;
  assign o_irq                  = |(raw & i_irq_mask);
endmodule

/* bench/gpd_port_chk.sv */
// concurrent checks on the gpio port outputs
`timescale 1ns/100ps
module gpd_port_chk #(
  parameter logic [7:0] DEBUG_PINS = 8'h00
) (
  input wire logic       i_clk, i_arst_n, i_data_wr, i_data_rd, i_cfg_we,
  input wire logic [9:0] i_data_addr,
  input wire logic [7:0] i_data_wdata, i_dir, i_irq_mask, o_data_rdata, o_pin, o_pin_oe,
  input wire logic [7:0] o_pin_direction_reg, o_alt_function_select, o_open_drain_enable,
  input wire logic [7:0] o_raw_irq_status, o_masked_irq_status,
  input wire logic       o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_rst; $rose(i_arst_n) |-> o_pin_oe == 8'h00 && o_pin_direction_reg == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  property p_dbg; $rose(i_arst_n) |-> o_alt_function_select == DEBUG_PINS; endproperty
  a_dbg: assert property (p_dbg) else $error("debug pin default wrong");
  property p_rdm; i_data_rd |=> (o_data_rdata & ~$past(i_data_addr[9:2])) == 8'h00; endproperty
  a_rdm: assert property (p_rdm) else $error("unmasked read bit not zero");
  property p_wrk; i_data_wr && &o_pin_direction_reg |=>
    ((o_pin ^ $past(o_pin)) & ~$past(i_data_addr[9:2])) == 8'h00; endproperty
  a_wrk: assert property (p_wrk) else $error("unmasked bit changed");
  property p_wrs; i_data_wr && &o_pin_direction_reg |=>
    ((o_pin ^ $past(i_data_wdata)) & $past(i_data_addr[9:2])) == 8'h00; endproperty
  a_wrs: assert property (p_wrs) else $error("masked bit not written");
  property p_oe; o_pin_oe == (o_pin_direction_reg & ~o_alt_function_select
    & ~(o_open_drain_enable & o_pin)); endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_cfg; i_cfg_we |=> o_pin_direction_reg == $past(i_dir); endproperty
  a_cfg: assert property (p_cfg) else $error("direction not loaded");
  property p_msk; o_masked_irq_status == (o_raw_irq_status & i_irq_mask) ##0
    o_irq == |o_masked_irq_status; endproperty
  a_msk: assert property (p_msk) else $error("masked status or irq wrong");
endmodule
bind gpd_port gpd_port_chk #(.DEBUG_PINS(DEBUG_PINS)) i_gpd_port_chk (.i_clk, .i_arst_n,
  .i_data_wr, .i_data_rd, .i_cfg_we, .i_data_addr, .i_data_wdata, .i_dir, .i_irq_mask,
  .o_data_rdata, .o_pin, .o_pin_oe, .o_pin_direction_reg, .o_alt_function_select,
  .o_open_drain_enable, .o_raw_irq_status, .o_masked_irq_status, .o_irq);

/* bench/gpd_pad_model.sv */
// external pad: resolves port drive against an outside source
`timescale 1ns/100ps
module gpd_pad_model (
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_ext,
  output logic      [7:0] o_level
);
  assign o_level = (i_pin_out & i_pin_oe) | (i_ext & ~i_pin_oe);
endmodule

/* bench/gpd_port_tb_top.sv */
// self-checking bench for the gpio port
`timescale 1ns/100ps
module gpd_port_tb_top;
  logic i_clk = 0, i_arst_n = 0, i_data_wr = 0, i_data_rd = 0, i_cfg_we = 0, i_irq_clear_we = 0;
  logic [9:0] i_data_addr = 10'h000;
  logic [7:0] i_data_wdata = 8'h00, i_dir = 8'h00, i_od = 8'h00, ext = 8'h00, pin;
  logic [7:0] i_sense = 8'h00, i_both = 8'h00, i_high = 8'h00, i_mask = 8'h00, i_clr = 8'h00;
  logic [7:0] rdata, o_pin, oe, dir, afs, den, pu, pd, raw, msk, od, slr;
  logic [7:0] i_afs = 8'h00;
  logic [15:0] i_drv = 16'h0000, drv;
  logic o_irq;
  int fail_count = 0, total_checks = 0;
  gpd_port #(.DEBUG_PINS(8'h0f)) i_gpd_port (.i_clk, .i_arst_n, .i_data_wr, .i_data_rd,
    .i_data_addr, .i_data_wdata, .o_data_rdata(rdata), .i_cfg_we, .i_dir,
    .i_alt_function_select(i_afs), .i_digital_input_enable(8'hff), .i_pull_up_enable(i_od),
    .i_pull_down_enable(~i_od), .i_open_drain_enable(i_od), .i_drive_sel(i_drv),
    .i_slew_enable(i_dir), .i_irq_sense_level(i_sense), .i_irq_both_edges(i_both),
    .i_irq_event_high(i_high), .i_irq_mask(i_mask), .i_irq_clear_we, .i_irq_clear_reg(i_clr),
    .i_pin(pin), .o_pin, .o_pin_oe(oe), .o_pin_direction_reg(dir), .o_alt_function_select(afs),
    .o_digital_input_enable(den), .o_pull_up_enable(pu), .o_pull_down_enable(pd),
    .o_open_drain_enable(od), .o_drive_sel(drv), .o_slew_enable(slr), .o_raw_irq_status(raw),
    .o_masked_irq_status(msk), .o_irq);
  gpd_pad_model i_gpd_pad_model (.i_pin_out(o_pin), .i_pin_oe(oe), .i_ext(ext), .o_level(pin));
  always #20 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    i_data_addr = a; i_data_wdata = d; i_data_wr = 1; cyc(1); i_data_wr = 0; cyc(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    i_data_addr = a; i_data_rd = 1; cyc(1); i_data_rd = 0; chk(rdata, exp); cyc(1);
  endtask
  task automatic cfg(input logic [7:0] d, input logic [7:0] od);
    i_dir = d; i_od = od; i_cfg_we = 1; cyc(1); i_cfg_we = 0; cyc(1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000; fail_count++; final_report;
  end
  initial begin
    cyc(5); i_arst_n = 1; cyc(1);
    chk(afs, 8'h0f); chk(den, 8'h0f); chk(pu, 8'h0f);
    chk(pd, 8'h00); chk(oe, 8'h00);
    chk(od, 8'h00); chk(slr, 8'h00); chk(drv[15:8], 8'h00); chk(drv[7:0], 8'h00);
    cfg(8'hff, 8'h00); wr(10'h3fc, 8'h00); wr(10'h098, 8'heb); chk(o_pin, 8'h22);
    chk(oe, 8'hff); chk(pin, 8'h22);
    wr(10'h3fc, 8'hff); rd(10'h0c4, 8'h31); rd(10'h3fc, 8'hff);
    i_afs = 8'h01; i_drv = 16'haa55; cfg(8'hff, 8'hf0); chk(oe, 8'h0e);
    chk(afs, 8'h01); chk(od, 8'hf0); chk(slr, 8'hf0); chk(drv[15:8], 8'haa);
    chk(drv[7:0], 8'h55); chk(pu, 8'hf0); chk(pd, 8'h0f); chk(den, 8'hff);
    cfg(8'h00, 8'h00); ext = 8'ha5; cyc(3); rd(10'h3fc, 8'ha5); rd(10'h004, 8'h01);
    i_high = 8'hff; cyc(4); i_clr = 8'hff; i_irq_clear_we = 1; cyc(1); i_irq_clear_we = 0;
    chk(raw, 8'h00);
    i_mask = 8'hff; ext = 8'hff; cyc(4); chk(raw, 8'h5a);
    chk(msk, 8'h5a); chk({7'h00, o_irq}, 8'h01);
    i_clr = 8'h0f; i_irq_clear_we = 1; cyc(1); i_irq_clear_we = 0; chk(raw, 8'h50);
    i_both = 8'hff; ext = 8'h00; cyc(4); chk(raw, 8'hff);
    i_sense = 8'hff; i_high = 8'h00; cyc(2); chk(raw, 8'hff);
    i_high = 8'hff; cyc(1); chk(raw, 8'h00); ext = 8'h81; cyc(3); chk(raw, 8'h81);
    i_mask = 8'h01; cyc(1); chk(msk, 8'h01); i_mask = 8'h00; cyc(1);
    chk({7'h00, o_irq}, 8'h00);
    cfg(8'hff, 8'h00); i_arst_n = 0; cyc(2); i_arst_n = 1; cyc(1);
    chk(afs, 8'h0f); chk(dir, 8'h00); chk(oe, 8'h00);
    final_report;
  end
endmodule
